// >>> rtl/evr_exc_seq.sv
// Exception vector address unit and reset sequencer with Wishbone registers
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module evr_exc_seq
   import evr_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   input  wire logic              power_on_reset_pin_n_i,
   input  wire logic              manual_reset_pin_n_i,
   input  wire logic              bus_busy_i,
   input  wire logic              exc_valid_i,
   input  wire evr_src_type       exc_src_i,
   input  wire logic [VEC_W-1:0]  exc_num_i,
   input  wire logic [3:0]        exc_level_i,
   input  wire logic [XLEN-1:0]   exc_ret_pc_i,
   output wire logic              exc_ready_o,
   output wire logic              mem_req_o,
   output wire logic              mem_we_o,
   output wire logic [XLEN-1:0]   mem_addr_o,
   output wire logic [XLEN-1:0]   mem_wdata_o,
   input  wire logic [XLEN-1:0]   mem_rdata_i,
   input  wire logic              mem_ack_i,
   output wire logic              core_reset_o,
   output wire logic              periph_reset_o,
   output wire logic              jump_o,
   output wire logic [XLEN-1:0]   pc_o,
   output wire logic [XLEN-1:0]   sp_o,
   output wire logic [XLEN-1:0]   status_word_o,
   output wire logic [XLEN-1:0]   vector_base_o,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [XLEN-1:0]   wb_dat_i,
   output wire logic [XLEN-1:0]   wb_dat_o,
   output wire logic              wb_ack_o
);

   evr_state_type    state_q;
   evr_state_type    state_d;
   logic             man_q;
   logic             man_d;
   logic             por_met;
   logic             man_met;
   logic             mem_state;
   logic             reset_done;
   logic             vec_done;
   logic             take_exc;
   logic [XLEN-1:0]  addr_q;
   logic [XLEN-1:0]  addr_d;
   logic [XLEN-1:0]  wdata_q;
   logic [XLEN-1:0]  wdata_d;
   logic             we_q;
   logic [XLEN-1:0]  pc_q;
   logic [XLEN-1:0]  pcfetch_q;
   logic [XLEN-1:0]  sp_q;
   logic [XLEN-1:0]  sr_q;
   logic [XLEN-1:0]  vbase_q;
   logic [VEC_W-1:0] vec_q;
   logic             intr_q;
   logic [3:0]       lvl_q;
   logic [XLEN-1:0]  retpc_q;
   logic             jump_q;
   logic             periph_rst_q;
   logic             wb_ack_q;
   logic [XLEN-1:0]  wb_dat_q;
   logic             wb_hit;
   logic             wb_wr;

   // Vector number of a requested exception source
   function automatic logic [VEC_W-1:0] map_vector(evr_src_type src, logic [VEC_W-1:0] num);
      logic [VEC_W-1:0] v;
      v = VEC_ILLEGAL;
      case (src)
         SRC_ILLEGAL:   v = VEC_ILLEGAL;
         SRC_SLOT:      v = VEC_SLOT;
         SRC_CPU_AERR:  v = VEC_CPU_AERR;
         SRC_XFER_AERR: v = VEC_XFER_AERR;
         SRC_NMI:       v = VEC_NMI;
         SRC_UBRK:      v = VEC_UBRK;
         SRC_TRAP:      v = VEC_TRAP_BASE + VEC_W'(num[TRAP_IDX_W-1:0]);
         SRC_IRQ:       v = VEC_IRQ_BASE + VEC_W'(num[IRQ_IDX_W-1:0]);
         SRC_PERIPH:    v = (num < VEC_PERIPH_MIN) ? VEC_PERIPH_MIN : num;
         default:       v = VEC_ILLEGAL;
      endcase
      return v;
   endfunction

   // Longword-aligned table offset of a vector number
   function automatic logic [XLEN-1:0] vec_off(logic [VEC_W-1:0] v);
      return XLEN'(v) << VEC_SHIFT;
   endfunction

   function automatic logic src_is_intr(evr_src_type src);
      return (src == SRC_NMI) || (src == SRC_UBRK) || (src == SRC_IRQ) || (src == SRC_PERIPH);
   endfunction

   evr_low_timer
   #(
      .MIN_CYC (RESET_MIN_CYC),
      .CNT_W   (RST_CNT_W)
   )
   u_por_timer
   (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .pin_n_i (power_on_reset_pin_n_i),
      .met_o   (por_met)
   );

   evr_low_timer
   #(
      .MIN_CYC (RESET_MIN_CYC),
      .CNT_W   (RST_CNT_W)
   )
   u_man_timer
   (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .pin_n_i (manual_reset_pin_n_i),
      .met_o   (man_met)
   );

   assign mem_state = (state_q == ST_FPC) || (state_q == ST_FSP) || (state_q == ST_PUSH_SR) ||
                      (state_q == ST_PUSH_PC) || (state_q == ST_FVEC);

   // No exception accepted while either reset pin is low
   assign exc_ready_o = (state_q == ST_RUN) && power_on_reset_pin_n_i
                        && manual_reset_pin_n_i;
   assign take_exc    = exc_valid_i && exc_ready_o;

   // Sequencer
   always_comb
   begin
      state_d = state_q;
      man_d   = man_q;
      if (!power_on_reset_pin_n_i)
      begin
         state_d = ST_POR;
         man_d   = 1'b0;
      end
      else
      begin
         case (state_q)
            ST_POR:
               if (por_met)
                  state_d = ST_FPC;
            ST_MWAIT:
               if (!bus_busy_i)
                  state_d = ST_MANUAL_RESET_PIN;
            ST_MANUAL_RESET_PIN:
               if (manual_reset_pin_n_i && man_met)
                  state_d = ST_FPC;
            ST_RUN:
               if (!manual_reset_pin_n_i)
               begin
                  man_d   = 1'b1;
                  state_d = bus_busy_i ? ST_MWAIT : ST_MANUAL_RESET_PIN;
               end
               else if (exc_valid_i)
                  state_d = ST_PUSH_SR;
            ST_FPC:
               if (mem_ack_i)
                  state_d = ST_FSP;
            ST_FSP:
               if (mem_ack_i)
                  state_d = ST_RUN;
            ST_PUSH_SR:
               if (mem_ack_i)
                  state_d = ST_PUSH_PC;
            ST_PUSH_PC:
               if (mem_ack_i)
                  state_d = ST_FVEC;
            ST_FVEC:
               if (mem_ack_i)
                  state_d = ST_RUN;
            default:
               state_d = ST_POR;
         endcase
         // Own transfer is cut only by the power-on pin; manual reset waits for its ack
         if (mem_state && mem_ack_i && !manual_reset_pin_n_i)
         begin
            man_d   = 1'b1;
            state_d = bus_busy_i ? ST_MWAIT : ST_MANUAL_RESET_PIN;
         end
      end
   end

   assign reset_done = (state_q == ST_FSP) && (state_d == ST_RUN);
   assign vec_done   = (state_q == ST_FVEC) && (state_d == ST_RUN);

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= ST_POR;
         man_q   <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         man_q   <= man_d;
      end
   end

   // Transfer address and write data, set on entry to each transfer state
   always_comb
   begin
      addr_d  = addr_q;
      wdata_d = wdata_q;
      case (state_d)
         ST_FPC:     addr_d = vec_off(man_d ? VEC_MAN_PC : VEC_POR_PC);
         ST_FSP:     addr_d = vec_off(man_d ? VEC_MAN_SP : VEC_POR_SP);
         ST_PUSH_SR:
         begin
            addr_d  = sp_q - STK_STEP;
            wdata_d = sr_q;
         end
         ST_PUSH_PC:
         begin
            addr_d  = sp_q - STK_STEP2;
            wdata_d = retpc_q;
         end
         ST_FVEC:    addr_d = vbase_q + vec_off(vec_q);
         default:    addr_d = addr_q;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         addr_q  <= '0;
         wdata_q <= '0;
         we_q    <= 1'b0;
      end
      else if (state_d != state_q)
      begin
         addr_q  <= {addr_d[XLEN-1:VEC_SHIFT], VEC_SHIFT'(0)};
         wdata_q <= wdata_d;
         we_q    <= (state_d == ST_PUSH_SR) || (state_d == ST_PUSH_PC);
      end
   end

   // Captured exception request
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         vec_q   <= VEC_ILLEGAL;
         intr_q  <= 1'b0;
         lvl_q   <= '0;
         retpc_q <= '0;
      end
      else if (take_exc)
      begin
         vec_q   <= map_vector(exc_src_i, exc_num_i);
         intr_q  <= src_is_intr(exc_src_i);
         retpc_q <= exc_ret_pc_i;
         if (exc_src_i == SRC_NMI)
            lvl_q <= MASK_NMI;
         else if (exc_src_i == SRC_UBRK)
            lvl_q <= UBRK_LEVEL;
         else
            lvl_q <= exc_level_i;
      end
   end

   // Byte-lane merge of a bus write
   function automatic logic [XLEN-1:0] merge(logic [XLEN-1:0] old, logic [XLEN-1:0] wr,
                                             logic [3:0] sel);
      logic [XLEN-1:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            r[i*8 +: 8] = wr[i*8 +: 8];
      end
      return r;
   endfunction

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_q;
   // Write lands at the acknowledging edge, with the request still held
   assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_q;

   // Hardware updates win over software writes in the same cycle
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         vbase_q <= VBASE_RESET;
      else if (reset_done)
         vbase_q <= VBASE_RESET;
      else if (wb_wr && (wb_adr_i == REG_VBASE))
         vbase_q <= merge(vbase_q, wb_dat_i, wb_sel_i);
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         sr_q <= SR_RESET;
      else if (reset_done)
         sr_q[MASK_MSB:MASK_LSB] <= MASK_RESET_VAL;
      else if ((state_q == ST_PUSH_PC) && (state_d == ST_FVEC) && intr_q)
         sr_q[MASK_MSB:MASK_LSB] <= lvl_q;
      else if (wb_wr && (wb_adr_i == REG_STATUS))
         sr_q <= merge(sr_q, wb_dat_i, wb_sel_i);
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         sp_q <= SP_RESET;
      else if (reset_done)
         sp_q <= mem_rdata_i;
      else if (((state_q == ST_PUSH_SR) || (state_q == ST_PUSH_PC)) && mem_ack_i)
         sp_q <= sp_q - STK_STEP;
      else if (wb_wr && (wb_adr_i == REG_STACK))
         sp_q <= merge(sp_q, wb_dat_i, wb_sel_i);
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         pcfetch_q <= PC_RESET;
      else if ((state_q == ST_FPC) && mem_ack_i)
         pcfetch_q <= mem_rdata_i;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         pc_q   <= PC_RESET;
         jump_q <= 1'b0;
      end
      else
      begin
         jump_q <= reset_done || vec_done;
         if (reset_done)
            pc_q <= pcfetch_q;
         else if (vec_done)
            pc_q <= mem_rdata_i;
      end
   end

   // Peripherals and the bus state unit see only the power-on pin
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         periph_rst_q <= 1'b1;
      else
         periph_rst_q <= !power_on_reset_pin_n_i;
   end

   // Wishbone slave: ack one cycle after the strobe, unmapped reads zero
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= '0;
      end
      else
      begin
         wb_ack_q <= wb_hit;
         if (wb_hit)
         begin
            case (wb_adr_i)
               REG_VBASE:   wb_dat_q <= vbase_q;
               REG_STATUS:  wb_dat_q <= sr_q;
               REG_STACK:   wb_dat_q <= sp_q;
               REG_PC:      wb_dat_q <= pc_q;
               REG_STATE:
               begin
                  wb_dat_q                 <= XLEN'(state_q);
                  wb_dat_q[STATE_POR_PIN]  <= power_on_reset_pin_n_i;
                  wb_dat_q[STATE_MAN_PIN]  <= manual_reset_pin_n_i;
                  wb_dat_q[STATE_MAN_FLAG] <= man_q;
               end
               REG_LASTVEC: wb_dat_q <= XLEN'(vec_q);
               default:     wb_dat_q <= '0;
            endcase
         end
      end
   end

   assign mem_req_o      = mem_state;
   assign mem_we_o       = we_q;
   assign mem_addr_o     = addr_q;
   assign mem_wdata_o    = wdata_q;
   assign core_reset_o   = (state_q == ST_POR) || (state_q == ST_MANUAL_RESET_PIN) ||
                           (state_q == ST_FPC) || (state_q == ST_FSP);
   assign periph_reset_o = periph_rst_q;
   assign jump_o         = jump_q;
   assign pc_o           = pc_q;
   assign sp_o           = sp_q;
   assign status_word_o  = sr_q;
   assign vector_base_o  = vbase_q;
   assign wb_dat_o       = wb_dat_q;
   assign wb_ack_o       = wb_ack_q;

endmodule

// >>> pkg/evr_pkg.sv
// Shared constants and types for the exception vector and reset sequencer
package evr_pkg;

   localparam int unsigned XLEN = 32;
   localparam int unsigned VEC_W = 8;
   localparam int unsigned ADR_W = 8;

   // Vector numbers
   localparam logic [VEC_W-1:0] VEC_POR_PC     = 8'h00;
   localparam logic [VEC_W-1:0] VEC_POR_SP     = 8'h01;
   localparam logic [VEC_W-1:0] VEC_MAN_PC     = 8'h02;
   localparam logic [VEC_W-1:0] VEC_MAN_SP     = 8'h03;
   localparam logic [VEC_W-1:0] VEC_ILLEGAL    = 8'h04;
   localparam logic [VEC_W-1:0] VEC_SLOT       = 8'h06;
   localparam logic [VEC_W-1:0] VEC_CPU_AERR   = 8'h09;
   localparam logic [VEC_W-1:0] VEC_XFER_AERR  = 8'h0A;
   localparam logic [VEC_W-1:0] VEC_NMI        = 8'h0B;
   localparam logic [VEC_W-1:0] VEC_UBRK       = 8'h0C;
   localparam logic [VEC_W-1:0] VEC_TRAP_BASE  = 8'h20;
   localparam logic [VEC_W-1:0] VEC_IRQ_BASE   = 8'h40;
   localparam logic [VEC_W-1:0] VEC_PERIPH_MIN = 8'h48;
   localparam int unsigned      TRAP_IDX_W     = 5;
   localparam int unsigned      IRQ_IDX_W      = 3;

   // Vector slot spacing is one longword
   localparam int unsigned      VEC_SHIFT      = 2;
   localparam logic [XLEN-1:0]  STK_STEP       = 32'h0000_0004;
   localparam logic [XLEN-1:0]  STK_STEP2      = 32'h0000_0008;

   // Reset values and status word layout
   localparam logic [XLEN-1:0]  VBASE_RESET    = 32'h0000_0000;
   localparam logic [XLEN-1:0]  SR_RESET       = 32'h0000_00F0;
   localparam logic [XLEN-1:0]  PC_RESET       = 32'h0000_0000;
   localparam logic [XLEN-1:0]  SP_RESET       = 32'h0000_0000;
   localparam int unsigned      MASK_LSB       = 4;
   localparam int unsigned      MASK_MSB       = 7;
   localparam logic [3:0]       MASK_RESET_VAL = 4'hF;
   localparam logic [3:0]       MASK_NMI       = 4'hF;
   localparam logic [3:0]       UBRK_LEVEL     = 4'hF;

   // Least reset pin low time, in clock cycles
   localparam int unsigned      RESET_MIN_CYC  = 20;
   localparam int unsigned      RST_CNT_W      = 5;

   // Register byte offsets
   localparam logic [ADR_W-1:0] REG_VBASE      = 8'h00;
   localparam logic [ADR_W-1:0] REG_STATUS     = 8'h04;
   localparam logic [ADR_W-1:0] REG_STACK      = 8'h08;
   localparam logic [ADR_W-1:0] REG_PC         = 8'h0C;
   localparam logic [ADR_W-1:0] REG_STATE      = 8'h10;
   localparam logic [ADR_W-1:0] REG_LASTVEC    = 8'h14;
   localparam int unsigned      STATE_POR_PIN  = 16;
   localparam int unsigned      STATE_MAN_PIN  = 17;
   localparam int unsigned      STATE_MAN_FLAG = 18;

   typedef enum logic [3:0] {
      SRC_ILLEGAL   = 4'h0,
      SRC_SLOT      = 4'h1,
      SRC_CPU_AERR  = 4'h2,
      SRC_XFER_AERR = 4'h3,
      SRC_NMI       = 4'h4,
      SRC_UBRK      = 4'h5,
      SRC_TRAP      = 4'h6,
      SRC_IRQ       = 4'h7,
      SRC_PERIPH    = 4'h8
   } evr_src_type;

   typedef enum logic [8:0] {
      ST_POR     = 9'h001,
      ST_MWAIT   = 9'h002,
      ST_MANUAL_RESET_PIN    = 9'h004,
      ST_FPC     = 9'h008,
      ST_FSP     = 9'h010,
      ST_RUN     = 9'h020,
      ST_PUSH_SR = 9'h040,
      ST_PUSH_PC = 9'h080,
      ST_FVEC    = 9'h100
   } evr_state_type;

endpackage

// >>> rtl/evr_low_timer.sv
// Counts how long an active-low reset pin has been held low
`timescale 1ns/1ps
module evr_low_timer
#(
   parameter int unsigned MIN_CYC = 20,
   parameter int unsigned CNT_W   = 5
)
(
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic pin_n_i,
   output wire logic met_o
);

   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(MIN_CYC);

   logic [CNT_W-1:0] cnt_q;

   // Saturates at the least low time; still valid in the first high cycle
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= '0;
      end
      else if (pin_n_i)
      begin
         cnt_q <= '0;
      end
      else if (cnt_q != CNT_MAX)
      begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   assign met_o = (cnt_q == CNT_MAX);

endmodule

// >>> bench/evr_exc_seq_properties.sv
// Port checker for the exception vector and reset sequencer
`timescale 1ns/1ps
module evr_exc_seq_props
   import evr_pkg::*;
(
   input wire logic            mclk_i,
   input wire logic            rst_n_i,
   input wire logic            power_on_reset_pin_n_i,
   input wire logic            manual_reset_pin_n_i,
   input wire logic            bus_busy_i,
   input wire logic            exc_valid_i,
   input wire logic            exc_ready_o,
   input wire logic            mem_req_o,
   input wire logic            mem_we_o,
   input wire logic [XLEN-1:0] mem_addr_o,
   input wire logic [XLEN-1:0] mem_wdata_o,
   input wire logic [XLEN-1:0] mem_rdata_i,
   input wire logic            mem_ack_i,
   input wire logic            core_reset_o,
   input wire logic            periph_reset_o,
   input wire logic            jump_o,
   input wire logic [XLEN-1:0] pc_o,
   input wire logic [XLEN-1:0] sp_o,
   input wire logic [XLEN-1:0] status_word_o,
   input wire logic [XLEN-1:0] vector_base_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   reset_done_a: assert property ($fell(core_reset_o) |-> jump_o &&
      vector_base_o == VBASE_RESET && status_word_o[MASK_MSB:MASK_LSB] == MASK_RESET_VAL)
      else $error("reset completion state wrong");
   reset_fetch_a: assert property (mem_req_o && core_reset_o |->
      !mem_we_o && mem_addr_o < 32'h0000_0010) else $error("reset fetch address wrong");
   fetch_order_a: assert property (core_reset_o && mem_req_o && mem_ack_i &&
      !mem_addr_o[2] && power_on_reset_pin_n_i && manual_reset_pin_n_i
      |=> mem_req_o && mem_addr_o == $past(mem_addr_o) + STK_STEP)
      else $error("stack pointer fetch out of order");
   por_hold_a: assert property (!power_on_reset_pin_n_i |=>
      core_reset_o && !mem_req_o) else $error("core ran with power-on pin low");
   periph_follow_a: assert property (1'b1 |=>
      periph_reset_o == !$past(power_on_reset_pin_n_i)) else $error("peripheral reset wrong");
   man_wait_a: assert property ($past(exc_ready_o) && power_on_reset_pin_n_i &&
      !manual_reset_pin_n_i && bus_busy_i |=> !core_reset_o)
      else $error("manual reset cut a bus cycle");
   push_status_a: assert property (exc_valid_i && exc_ready_o |=> mem_req_o &&
      mem_we_o && mem_addr_o == $past(sp_o) - STK_STEP && mem_wdata_o == $past(status_word_o))
      else $error("status push wrong");
   vec_jump_a: assert property (mem_req_o && !mem_we_o && !core_reset_o && mem_ack_i &&
      power_on_reset_pin_n_i && manual_reset_pin_n_i |=> jump_o && pc_o == $past(mem_rdata_i))
      else $error("vector jump wrong");
   word_align_a: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'b00)
      else $error("unaligned transfer");
   xfer_hold_a: assert property (mem_req_o && !mem_ack_i && power_on_reset_pin_n_i
      |=> mem_req_o && $stable(mem_addr_o)) else $error("transfer cut before ack");
endmodule

bind evr_exc_seq evr_exc_seq_props evr_exc_seq_props_i (.*);

// >>> bench/evr_mem_model.sv
// Memory slave answering vector reads and stack pushes
`timescale 1ns/1ps
module evr_mem_model
(
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic [1:0]  wait_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [31:0] addr_i,
   output logic      [31:0] rdata_o,
   output logic             ack_o,
   output logic      [31:0] last_rd_o
);
   logic [1:0] cnt_q;
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 2'b00;
         ack_o <= 1'b0;
         rdata_o <= 32'hFFFF_0000;
         last_rd_o <= 32'hFFFF_FFFF;
      end
      else if (!req_i || ack_o)
      begin
         cnt_q <= 2'b00;
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
      end
      else if (cnt_q == wait_i)
      begin
         ack_o <= 1'b1;
         rdata_o <= we_i ? ~rdata_o : {addr_i[15:0] ^ 16'h5A5A, addr_i[15:0]};
         if (!we_i)
            last_rd_o <= addr_i;
      end
      else
         cnt_q <= cnt_q + 2'b01;
   end
endmodule

// >>> bench/test_evr_exc_seq.sv
// Self-checking bench for the exception vector and reset sequencer
`timescale 1ns/1ps
module test_evr_exc_seq
   import evr_pkg::*;
;
   logic              mclk_i = 1'b0;
   logic              rst_n_i, power_on_reset_pin_n_i, manual_reset_pin_n_i, bus_busy_i;
   logic              exc_valid_i, exc_ready_o, mem_req_o, mem_we_o, mem_ack_i;
   evr_src_type       exc_src_i;
   logic [VEC_W-1:0]  exc_num_i;
   logic [3:0]        exc_level_i, wb_sel_i;
   logic [XLEN-1:0]   exc_ret_pc_i, mem_addr_o, mem_wdata_o, mem_rdata_i, pc_o, sp_o;
   logic              core_reset_o, periph_reset_o, jump_o, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [XLEN-1:0]   status_word_o, vector_base_o, wb_dat_i, wb_dat_o, last_rd, vb, rd;
   logic [ADR_W-1:0]  wb_adr_i;
   logic [1:0]        mem_wait;
   int                err_count = 0;
   int                checks = 0;

   evr_exc_seq evr_exc_seq_i (.*);
   evr_mem_model evr_mem_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wait_i(mem_wait),
      .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o), .rdata_o(mem_rdata_i),
      .ack_o(mem_ack_i), .last_rd_o(last_rd));

   always #2.5 mclk_i = ~mclk_i;

   function automatic logic [31:0] word_at(input logic [31:0] a);
      return {a[15:0] ^ 16'h5A5A, a[15:0]};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_up;
      err_count++;
      results();
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge mclk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do @(posedge mclk_i); while (wb_ack_o !== 1'b1 && n++ < 100);
      if (wb_ack_o !== 1'b1) give_up();
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic wait_jump;
      int n = 0;
      do @(negedge mclk_i); while (jump_o !== 1'b1 && n++ < 500);
      if (jump_o !== 1'b1) give_up();
   endtask

   task automatic exc(input evr_src_type s, input logic [7:0] num, input logic [3:0] lvl,
                      input logic [7:0] vec, input logic [3:0] mask);
      int n = 0;
      @(posedge mclk_i);
      exc_valid_i <= 1'b1;
      exc_src_i <= s;
      exc_num_i <= num;
      exc_level_i <= lvl;
      exc_ret_pc_i <= {24'h0000_10, vec};
      do @(posedge mclk_i); while (exc_ready_o !== 1'b1 && n++ < 100);
      if (exc_ready_o !== 1'b1) give_up();
      exc_valid_i <= 1'b0;
      wait_jump();
      check(last_rd, vb + {22'd0, vec, 2'b00});
      check(pc_o, word_at(vb + {22'd0, vec, 2'b00}));
      check({28'd0, status_word_o[7:4]}, {28'd0, mask});
   endtask

   task automatic results;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #100us;
      err_count++;
      results();
   end

   initial
   begin
      {rst_n_i, power_on_reset_pin_n_i, manual_reset_pin_n_i, bus_busy_i} = 4'b0010;
      {exc_valid_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b0000;
      exc_src_i = SRC_ILLEGAL;
      {exc_num_i, exc_level_i, wb_adr_i, wb_sel_i, mem_wait} = {8'h00, 4'h0, 8'h00, 4'hF, 2'b00};
      {exc_ret_pc_i, wb_dat_i, vb} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      power_on_reset_pin_n_i <= 1'b1;
      repeat (10) @(negedge mclk_i);
      check(core_reset_o, 1'b1);
      check(mem_req_o, 1'b0);
      @(posedge mclk_i);
      power_on_reset_pin_n_i <= 1'b0;
      repeat (20) @(posedge mclk_i);
      power_on_reset_pin_n_i <= 1'b1;
      wait_jump();
      check(pc_o, word_at(32'h0000_0000));
      check(sp_o, word_at(32'h0000_0004));
      check(vector_base_o, 32'h0000_0000);
      check(periph_reset_o, 1'b0);
      wb(1'b1, 8'h00, 32'h0000_1000);
      vb = 32'h0000_1000;
      wb(1'b0, 8'h00, 32'h0000_0000);
      check(rd, vb);
      wb(1'b0, 8'h24, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      wb(1'b1, 8'h0C, 32'h0000_0BAD);
      wb(1'b0, 8'h0C, 32'h0000_0000);
      check(rd, word_at(32'h0000_0000));
      exc(SRC_ILLEGAL, 8'h00, 4'h0, 8'h04, 4'hF);
      mem_wait <= 2'b11;
      exc(SRC_SLOT, 8'h00, 4'h0, 8'h06, 4'hF);
      exc(SRC_CPU_AERR, 8'h00, 4'h0, 8'h09, 4'hF);
      mem_wait <= 2'b01;
      exc(SRC_XFER_AERR, 8'h00, 4'h0, 8'h0A, 4'hF);
      exc(SRC_TRAP, 8'h05, 4'h0, 8'h25, 4'hF);
      exc(SRC_IRQ, 8'h07, 4'h3, 8'h47, 4'h3);
      exc(SRC_UBRK, 8'h00, 4'h0, 8'h0C, 4'hF);
      exc(SRC_PERIPH, 8'hC8, 4'h9, 8'hC8, 4'h9);
      exc(SRC_ILLEGAL, 8'h00, 4'h0, 8'h04, 4'h9);
      exc(SRC_NMI, 8'h00, 4'h0, 8'h0B, 4'hF);
      exc(SRC_PERIPH, 8'h0A, 4'h2, 8'h48, 4'h2);
      mem_wait <= 2'b00;
      exc(SRC_IRQ, 8'h00, 4'h5, 8'h40, 4'h5);
      exc(SRC_PERIPH, 8'hFF, 4'h1, 8'hFF, 4'h1);
      @(posedge mclk_i);
      bus_busy_i <= 1'b1;
      manual_reset_pin_n_i <= 1'b0;
      exc_valid_i <= 1'b1;
      repeat (25) @(negedge mclk_i);
      check(exc_ready_o, 1'b0);
      check(core_reset_o, 1'b0);
      @(posedge mclk_i);
      bus_busy_i <= 1'b0;
      repeat (3) @(negedge mclk_i);
      check(core_reset_o, 1'b1);
      check(periph_reset_o, 1'b0);
      repeat (20) @(posedge mclk_i);
      manual_reset_pin_n_i <= 1'b1;
      exc_valid_i <= 1'b0;
      wait_jump();
      check(pc_o, word_at(32'h0000_0008));
      check(sp_o, word_at(32'h0000_000C));
      check(vector_base_o, 32'h0000_0000);
      vb = 32'h0000_0000;
      exc(SRC_ILLEGAL, 8'h00, 4'h0, 8'h04, 4'hF);
      mem_wait <= 2'b11;
      @(posedge mclk_i);
      exc_valid_i <= 1'b1;
      exc_src_i <= SRC_IRQ;
      exc_level_i <= 4'h2;
      @(posedge mclk_i);
      exc_valid_i <= 1'b0;
      manual_reset_pin_n_i <= 1'b0;
      repeat (15) @(negedge mclk_i);
      check(core_reset_o, 1'b1);
      check({28'd0, status_word_o[7:4]}, 32'h0000_000F);
      repeat (15) @(posedge mclk_i);
      manual_reset_pin_n_i <= 1'b1;
      wait_jump();
      check(pc_o, word_at(32'h0000_0008));
      results();
   end
endmodule
